// ---- src/adc_conversion_control_map.vh ----
`ifndef ADC_CONVERSION_CONTROL_MAP_VH
`define ADC_CONVERSION_CONTROL_MAP_VH
// register offsets on the plain register port
`define ADDR_CONVERTER_CONTROL_0 4'h0
`define ADDR_RESULT_HIGH 4'h1
`define ADDR_RESULT_LOW 4'h2
`define ADDR_PERIPHERAL_IRQ_ENABLE_ONE 4'h3
`define ADDR_IRQ_CONTROL 4'h4
`define ADDR_CONVERSION_FLAGS 4'h5
// field positions
`define BIT_CONVERTER_ON 0
`define BIT_GO_DONE 1
`define BIT_CONVERSION_IRQ_ENABLE 6
`define BIT_PERIPHERAL_IRQ_GATE 6
`define BIT_CONVERSION_DONE_FLAG 6
// reset values
`define RESET_BYTE 8'h00
// conversion timing: bit-resolve periods per bit
`define CONVERSION_BITS 10
`define CYCLES_PER_BIT 4
`endif

// ---- src/adc_conversion_control.v ----
// Decided for this implementation: the address-and-strobe port and the register offsets.
`timescale 1ns/100ps
`include "adc_conversion_control_map.vh"
module adc_conversion_control #(
  parameter NBITS = `CONVERSION_BITS, // result width, msb resolved first
  parameter BIT_CYCLES = `CYCLES_PER_BIT // clocks spent on each bit
) (
  // system clock
  input wire MCLK,
  // asynchronous device reset, active high
  input wire RST,
  // register address
  input wire [3:0] ADDR,
  // register write data
  input wire [7:0] WDATA,
  // one-cycle write strobe
  input wire WR,
  // one-cycle read strobe
  input wire RD,
  // read data, valid the cycle after the strobe
  output reg [7:0] RDATA,
  // comparator answer from the analog core
  input wire COMPARE_IN,
  // power request to the analog core
  output wire CONVERTER_POWER,
  // high while a conversion runs
  output wire SAMPLE_ACTIVE,
  // converter interrupt request to the core
  output wire IRQ
);

  // one-hot sequencer states
  localparam ST_IDLE = 2'b01; // waiting for go
  localparam ST_CONV = 2'b10; // resolving bits

  // sized copies of the parameters, so compares never truncate silently
  localparam [3:0] TOP_INDEX = NBITS - 1; // index of the msb
  localparam [7:0] LAST_SLOT = BIT_CYCLES - 1; // final cycle of a bit slot

  // control and status storage
  reg [1:0] state; // one-hot state
  reg converter_on; // power control bit
  reg go_done; // busy bit, reads back as set while converting
  reg conversion_done_flag; // sticky completion flag
  reg [7:0] peripheral_irq_enable_one; // enable byte, only bit 6 used here
  reg peripheral_irq_gate; // peripheral interrupt gate

  // successive approximation storage
  reg [NBITS-1:0] sar; // trial/resolved bits, msb first
  reg [NBITS-1:0] result; // stored result
  reg [3:0] bit_index; // bit being resolved
  reg [7:0] bit_timer; // cycles within one bit
  reg last_bit; // value of last resolved bit, 0 before any
  reg [NBITS-1:0] filled; // abort fill value

  // address decode of the write strobe
  wire wr_ctrl = WR && (ADDR == `ADDR_CONVERTER_CONTROL_0); // control write
  wire wr_enable = WR && (ADDR == `ADDR_PERIPHERAL_IRQ_ENABLE_ONE); // enable write
  wire wr_irq_ctl = WR && (ADDR == `ADDR_IRQ_CONTROL); // gate write
  wire wr_flags = WR && (ADDR == `ADDR_CONVERSION_FLAGS); // flag write

  // sequencer events
  wire converting = state[1]; // conversion in progress
  // go must come with the power bit kept on in the same write
  wire go_write = wr_ctrl && WDATA[`BIT_GO_DONE] && WDATA[`BIT_CONVERTER_ON];
  // clearing go, or dropping power, ends a running conversion
  wire abort_write = wr_ctrl && (!WDATA[`BIT_GO_DONE] || !WDATA[`BIT_CONVERTER_ON]);
  // a go in the very write that powers up is refused
  wire start = state[0] && go_write && converter_on;
  wire stop = converting && abort_write;
  wire bit_tick = converting && (bit_timer == LAST_SLOT); // end of a bit slot
  wire finish = bit_tick && (bit_index == 4'h0) && !stop; // last bit resolved
  integer i; // fill loop index

  assign CONVERTER_POWER = converter_on;
  assign SAMPLE_ACTIVE = converting; // analog core busy indication
  // gate is the master condition for any peripheral source
  assign IRQ = peripheral_irq_gate && conversion_done_flag &&
               peripheral_irq_enable_one[`BIT_CONVERSION_IRQ_ENABLE];

  // partial result: the bit in trial and all below copy the last resolved one
  always @* begin
    filled = sar;
    for (i = 0; i < NBITS; i = i + 1) begin
      if (i <= bit_index) begin
        filled[i] = last_bit;
      end
    end
  end

  // power bit; clearing it mid-conversion also aborts, see stop
  always @(posedge MCLK or posedge RST) begin
    if (RST) begin
      converter_on <= 1'b0;
    end else if (wr_ctrl) begin
      converter_on <= WDATA[`BIT_CONVERTER_ON];
    end
  end

  // per-source enable byte, all bits stored for software
  always @(posedge MCLK or posedge RST) begin
    if (RST) begin
      peripheral_irq_enable_one <= `RESET_BYTE;
    end else if (wr_enable) begin
      peripheral_irq_enable_one <= WDATA;
    end
  end

  // peripheral gate bit
  always @(posedge MCLK or posedge RST) begin
    if (RST) begin
      peripheral_irq_gate <= 1'b0;
    end else if (wr_irq_ctl) begin
      peripheral_irq_gate <= WDATA[`BIT_PERIPHERAL_IRQ_GATE];
    end
  end

  // completion flag; a set in the same cycle as a clear wins,
  // so software can never lose a completion it has not seen
  always @(posedge MCLK or posedge RST) begin
    if (RST) begin
      conversion_done_flag <= 1'b0;
    end else if (finish) begin
      conversion_done_flag <= 1'b1;
    end else if (wr_flags && !WDATA[`BIT_CONVERSION_DONE_FLAG]) begin
      conversion_done_flag <= 1'b0; // writing 0 clears
    end
  end

  // sequencer state
  always @(posedge MCLK or posedge RST) begin
    if (RST) begin
      state <= ST_IDLE;
    end else begin
      case (state)
        ST_IDLE: begin
          if (start) begin
            state <= ST_CONV;
          end
        end
        ST_CONV: begin
          // abort has priority over a finish in the same cycle
          if (stop || finish) begin
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE; // illegal code recovers to idle
        end
      endcase
    end
  end

  // go/done bit mirrors the sequencer for software reads
  always @(posedge MCLK or posedge RST) begin
    if (RST) begin
      go_done <= 1'b0;
    end else if (start) begin
      go_done <= 1'b1;
    end else if (stop || finish) begin
      go_done <= 1'b0;
    end
  end

  // bit slot timing and trial bits
  always @(posedge MCLK or posedge RST) begin
    if (RST) begin
      sar <= {NBITS{1'b0}};
      bit_index <= 4'h0;
      bit_timer <= 8'h00;
      last_bit <= 1'b0;
    end else if (start) begin
      // msb goes on trial first; nothing resolved yet
      sar <= {1'b1, {(NBITS-1){1'b0}}};
      bit_index <= TOP_INDEX;
      bit_timer <= 8'h00;
      last_bit <= 1'b0;
    end else if (converting && !stop) begin
      if (bit_tick) begin
        bit_timer <= 8'h00;
        sar[bit_index] <= COMPARE_IN; // keep or drop trial bit
        last_bit <= COMPARE_IN;
        if (bit_index != 4'h0) begin
          sar[bit_index - 4'h1] <= 1'b1; // next trial bit
          bit_index <= bit_index - 4'h1;
        end
      end else begin
        bit_timer <= bit_timer + 8'h01;
      end
    end
  end

  // result registers: full result on finish, filled partial on abort
  always @(posedge MCLK or posedge RST) begin
    if (RST) begin
      result <= {NBITS{1'b0}};
    end else if (stop) begin
      result <= filled;
    end else if (finish) begin
      result <= {sar[NBITS-1:1], COMPARE_IN};
    end
  end

  // read data one cycle after the strobe; unmapped reads zero
  always @(posedge MCLK or posedge RST) begin
    if (RST) begin
      RDATA <= 8'h00;
    end else if (RD) begin
      case (ADDR)
        `ADDR_CONVERTER_CONTROL_0: RDATA <= {6'h00, go_done, converter_on};
        `ADDR_RESULT_HIGH: RDATA <= {6'h00, result[NBITS-1:NBITS-2]};
        `ADDR_RESULT_LOW: RDATA <= result[7:0];
        `ADDR_PERIPHERAL_IRQ_ENABLE_ONE: RDATA <= peripheral_irq_enable_one;
        `ADDR_IRQ_CONTROL: RDATA <= {1'b0, peripheral_irq_gate, 6'h00};
        `ADDR_CONVERSION_FLAGS: RDATA <= {1'b0, conversion_done_flag, 6'h00};
        default: RDATA <= 8'h00;
      endcase
    end else begin
      // data stands for one cycle only
      RDATA <= 8'h00;
    end
  end
endmodule

// ---- verification/adc_conversion_control_sva.sv ----
`timescale 1ns/100ps
module adc_conversion_control_sva #(parameter NBITS = 10, BIT_CYCLES = 4) (
  input wire MCLK, input wire RST, input wire [3:0] ADDR, input wire [7:0] WDATA, input wire WR,
  input wire CONVERTER_POWER, input wire SAMPLE_ACTIVE, input wire IRQ);
  localparam int CONV = NBITS * BIT_CYCLES;
  default clocking @(posedge MCLK); endclocking
  default disable iff (RST);
  wire ctl = WR && ADDR == 4'h0; // control register write
  a_power_follows: assert property (
    ctl |=> CONVERTER_POWER == $past(WDATA[0])) else $error("power");
  a_go_refused: assert property (
    ctl && WDATA[1] && !CONVERTER_POWER |=> !SAMPLE_ACTIVE) else $error("go");
  a_go_starts: assert property (
    ctl && WDATA[1:0] == 2'b11 && CONVERTER_POWER |=> SAMPLE_ACTIVE) else $error("start");
  a_abort_stops: assert property (
    SAMPLE_ACTIVE && ctl && !WDATA[1] |=> !SAMPLE_ACTIVE) else $error("abort");
  a_conv_bounded: assert property (
    $rose(SAMPLE_ACTIVE) |-> ##[1:CONV] !SAMPLE_ACTIVE) else $error("length");
  a_gate_masks: assert property (
    WR && ADDR == 4'h4 && !WDATA[6] |=> !IRQ) else $error("gate");
  a_enable_masks: assert property (
    WR && ADDR == 4'h3 && !WDATA[6] |=> !IRQ) else $error("mask");
  a_reset_clean: assert property (
    $fell(RST) |-> !(CONVERTER_POWER || SAMPLE_ACTIVE || IRQ)) else $error("reset");
  c_start: cover property ($rose(SAMPLE_ACTIVE));
  c_abort: cover property (SAMPLE_ACTIVE && ctl && !WDATA[1]);
  c_irq: cover property ($rose(IRQ));
endmodule
bind adc_conversion_control adc_conversion_control_sva
  #(.NBITS(NBITS), .BIT_CYCLES(BIT_CYCLES)) chk (
  .MCLK(MCLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .CONVERTER_POWER(CONVERTER_POWER),
  .SAMPLE_ACTIVE(SAMPLE_ACTIVE), .IRQ(IRQ));

// ---- verification/sar_core_model.sv ----
`timescale 1ns/100ps
module sar_core_model #(parameter [9:0] CODE = 10'h2A5) (input wire clk, input wire busy, output wire cmp);
  integer n = 0; // cycles into the conversion, 4 per bit
  reg junk = 1'b0; // toggles so a stale answer is never mistaken for a good one
  always @(posedge clk) begin
    n <= busy ? n + 1 : 0;
    junk <= ~junk;
  end
  assign cmp = (busy && n < 40) ? CODE[9 - n / 4] : junk;
endmodule

// ---- verification/adc_conversion_control_bench.sv ----
`timescale 1ns/100ps
module adc_conversion_control_bench;
  localparam [9:0] CODE = 10'h2A5;
  reg clk = 0, rst = 1, wr = 0, rd = 0;
  reg [3:0] a = 4'h0;
  reg [7:0] d = 8'h00;
  wire [7:0] q;
  wire cmp, pwr, busy, irq;
  integer fails = 0, n_tests = 0, i;
  adc_conversion_control dut (.MCLK(clk), .RST(rst), .ADDR(a), .WDATA(d), .WR(wr), .RD(rd),
    .RDATA(q), .COMPARE_IN(cmp), .CONVERTER_POWER(pwr), .SAMPLE_ACTIVE(busy), .IRQ(irq));
  sar_core_model #(.CODE(CODE)) core (.clk(clk), .busy(busy), .cmp(cmp));
  initial forever #50 clk = ~clk;
  task chk(input [7:0] g, input [7:0] e);
    n_tests = n_tests + 1;
    if (g !== e) begin
      fails = fails + 1;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task final_report;
    if (fails == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task w(input [3:0] x, input [7:0] y);
    {a, d, wr} <= {x, y, 1'b1};
    @(posedge clk) wr <= 1'b0;
    @(posedge clk);
  endtask
  task r(input [3:0] x, input [7:0] e);
    {a, rd} <= {x, 1'b1};
    @(posedge clk) rd <= 1'b0;
    #1 chk(q, e);
    @(posedge clk);
  endtask
  task t_reset;
    for (i = 0; i < 16; i = i + 1) r(i[3:0], 8'h00);
  endtask
  task t_same;
    w(4'h0, 8'h03);
    r(4'h0, 8'h01);
    chk({7'h00, pwr}, 8'h01);
  endtask
  task t_conv;
    w(4'h0, 8'h03);
    r(4'h0, 8'h03);
    repeat (40) @(posedge clk);
    r(4'h0, 8'h01);
    r(4'h1, {6'h00, CODE[9:8]});
    r(4'h2, CODE[7:0]);
    r(4'h5, 8'h40);
  endtask
  task t_irq;
    w(4'h3, 8'h40);
    w(4'h4, 8'h40);
    chk({7'h00, irq}, 8'h01);
    w(4'h3, 8'h00);
    chk({7'h00, irq}, 8'h00);
    w(4'h3, 8'h40);
    w(4'h4, 8'h00);
    chk({7'h00, irq}, 8'h00);
  endtask
  // abort mid fourth bit: three bits resolved, the rest copy the third
  task t_abort;
    w(4'h0, 8'h03);
    repeat (12) @(posedge clk);
    w(4'h0, 8'h01);
    chk({7'h00, busy}, 8'h00);
    r(4'h1, {6'h00, CODE[9:8]});
    r(4'h2, {CODE[7], 7'h7F});
  endtask
  // abort mid third bit: two bits resolved, the trial bit copies the second
  task t_abort_early;
    w(4'h0, 8'h03);
    repeat (8) @(posedge clk);
    w(4'h0, 8'h01);
    r(4'h1, {6'h00, CODE[9:8]});
    r(4'h2, {8{CODE[8]}});
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset;
    t_same;
    t_conv;
    t_irq;
    t_abort;
    t_abort_early;
    final_report;
  end
endmodule
